// ### rtl/ddc_decoder.sv
module ddc_decoder #(
	parameter bit TWO_DIE = 1'b1
) (
	input  wire logic                         clock,
	input  wire logic                         rst,
	input  wire logic                         reset_n,
	input  wire logic                         die0_select_n,
	input  wire logic                         die1_select_n,
	input  wire logic                         write_n,
	input  wire logic                         refresh_n,
	input  wire logic [ddc_pkg::ADDR_W-1:0]   addr,
	input  wire logic [ddc_pkg::BANK_W-1:0]   bank_addr,
	input  wire logic                         write_mask,
	input  wire logic                         write_beat,
	output logic      [ddc_pkg::NUM_DIE-1:0]  cmd_die_ff,
	output logic                              cmd_valid_ff,
	output logic      [4:0]                   cmd_code_ff,
	output logic      [ddc_pkg::ADDR_W-1:0]   cmd_addr_ff,
	output logic      [15:0]                  cmd_banks_ff,
	output logic                              refresh_multibank_ff,
	output logic                              beat_store_ff,
	output logic      [ddc_pkg::MR_W-1:0]     mode_reg_zero_ff,
	output logic      [ddc_pkg::MR_W-1:0]     mode_reg_one_ff,
	output logic      [ddc_pkg::MR_W-1:0]     mode_reg_two_ff,
	output logic      [3:0]                   row_cycle_time_ff,
	output logic                              illegal_cmd_ff
);

	// Reset pin synchroniser: three stages, change taken when stages two and three agree
	logic [2:0] rstn_sync_ff;
	logic       rstn_ok_ff;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			rstn_sync_ff <= 3'h7;
		else
			rstn_sync_ff <= {rstn_sync_ff[1:0], reset_n};
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			rstn_ok_ff <= 1'b1;
		else if (rstn_sync_ff[1] == rstn_sync_ff[2])
			rstn_ok_ff <= rstn_sync_ff[2];
	end

	// Decode one select group to a command
	function automatic ddc_pkg::ddc_cmd_t decode_cmd(input logic sel_n, input logic we_n, input logic ref_n);
		if (sel_n)
			decode_cmd = ddc_pkg::CMD_NOP;
		else
		begin
			unique case ({we_n, ref_n})
				2'b00: decode_cmd = ddc_pkg::CMD_MRS;
				2'b11: decode_cmd = ddc_pkg::CMD_READ;
				2'b01: decode_cmd = ddc_pkg::CMD_WRITE;
				2'b10: decode_cmd = ddc_pkg::CMD_AUTO_REFRESH_CMD;
			endcase
		end
	endfunction

	function automatic logic [15:0] bank_mask(input logic [3:0] ba, input logic [1:0] wmode);
		logic [15:0] m;
		m = 16'h0000;
		for (int i = 0; i < 16; i++)
		begin
			unique case (wmode)
				ddc_pkg::WMODE_DUAL: m[i] = (i[2:0] == ba[2:0]);
				ddc_pkg::WMODE_QUAD: m[i] = (i[1:0] == ba[1:0]);
				default:             m[i] = (i[3:0] == ba);
			endcase
		end
		bank_mask = m;
	endfunction

	// Input capture register on the command clock edge
	logic                        sel0_n_ff;
	logic                        sel1_n_ff;
	logic                        we_n_ff;
	logic                        ref_n_ff;
	logic [ddc_pkg::ADDR_W-1:0]  addr_ff;
	logic [ddc_pkg::BANK_W-1:0]  ba_ff;
	logic                        mask_ff;
	logic                        beat_ff;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sel0_n_ff <= 1'b1;
			sel1_n_ff <= 1'b1;
			we_n_ff   <= 1'b1;
			ref_n_ff  <= 1'b1;
			addr_ff   <= '0;
			ba_ff     <= '0;
			mask_ff   <= 1'b1;
			beat_ff   <= 1'b0;
		end
		else
		begin
			sel0_n_ff <= die0_select_n;
			sel1_n_ff <= TWO_DIE ? die1_select_n : die0_select_n;
			we_n_ff   <= write_n;
			ref_n_ff  <= refresh_n;
			addr_ff   <= addr;
			ba_ff     <= bank_addr;
			mask_ff   <= write_mask;
			beat_ff   <= write_beat;
		end
	end

	ddc_pkg::ddc_cmd_t cmd;
	logic [1:0]        die_hit;
	logic              illegal;

	always_comb
	begin
		cmd     = decode_cmd(sel0_n_ff & sel1_n_ff, we_n_ff, ref_n_ff);
		die_hit = TWO_DIE ? {~sel1_n_ff, ~sel0_n_ff} : {1'b0, ~sel0_n_ff};
		illegal = 1'b0;
		// Read or write to both dies is undefined; dropped rather than risk a bus clash
		if (TWO_DIE && (die_hit == 2'b11) && (cmd == ddc_pkg::CMD_READ || cmd == ddc_pkg::CMD_WRITE))
		begin
			illegal = 1'b1;
			cmd     = ddc_pkg::CMD_NOP;
			die_hit = 2'b00;
		end
	end

	logic [1:0] wmode;
	logic       multibank;

	assign wmode     = mode_reg_two_ff[ddc_pkg::MR2_WMODE_MSB:ddc_pkg::MR2_WMODE_LSB];
	assign multibank = mode_reg_two_ff[ddc_pkg::MR2_REFMODE_BIT];

	// Mode registers; one copy shared by both dies since both are set together in practice
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			mode_reg_zero_ff <= ddc_pkg::MR_RESET_VAL;
			mode_reg_one_ff  <= ddc_pkg::MR_RESET_VAL;
			mode_reg_two_ff  <= ddc_pkg::MR_RESET_VAL;
		end
		else if (!rstn_ok_ff)
		begin
			mode_reg_zero_ff <= ddc_pkg::MR_RESET_VAL;
			mode_reg_one_ff  <= ddc_pkg::MR_RESET_VAL;
			mode_reg_two_ff  <= ddc_pkg::MR_RESET_VAL;
		end
		else if (cmd == ddc_pkg::CMD_MRS)
		begin
			if (ba_ff == ddc_pkg::MR_SEL_ZERO)
				mode_reg_zero_ff <= {ba_ff, addr_ff};
			if (ba_ff == ddc_pkg::MR_SEL_ONE)
				mode_reg_one_ff <= {ba_ff, addr_ff};
			if (ba_ff == ddc_pkg::MR_SEL_TWO)
				mode_reg_two_ff <= {ba_ff, addr_ff};
		end
	end

	assign row_cycle_time_ff = mode_reg_zero_ff[ddc_pkg::MR0_RC_MSB:ddc_pkg::MR0_RC_LSB];

	// Issued command: one pulse per accepted command, nothing on no-operation
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cmd_valid_ff         <= 1'b0;
			cmd_code_ff          <= ddc_pkg::CMD_NOP;
			cmd_die_ff           <= 2'b00;
			illegal_cmd_ff       <= 1'b0;
		end
		else
		begin
			cmd_valid_ff   <= (cmd != ddc_pkg::CMD_NOP) && rstn_ok_ff;
			cmd_code_ff    <= cmd;
			// While the reset pin is held low no die is reported as targeted
			cmd_die_ff     <= (cmd == ddc_pkg::CMD_NOP || !rstn_ok_ff) ? 2'b00 : die_hit;
			illegal_cmd_ff <= illegal;
		end
	end

	// Address and bank targets hold their last value across no-operation
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cmd_addr_ff          <= '0;
			cmd_banks_ff         <= 16'h0000;
			refresh_multibank_ff <= 1'b0;
		end
		else
		begin
			unique case (cmd)
				ddc_pkg::CMD_READ:
				begin
					cmd_addr_ff  <= addr_ff;
					cmd_banks_ff <= bank_mask(ba_ff, ddc_pkg::WMODE_SINGLE);
				end
				ddc_pkg::CMD_WRITE:
				begin
					cmd_addr_ff  <= addr_ff;
					cmd_banks_ff <= bank_mask(ba_ff, wmode);
				end
				ddc_pkg::CMD_AUTO_REFRESH_CMD:
				begin
					refresh_multibank_ff <= multibank;
					if (multibank)
					begin
						// Multibank: only address inputs; low sixteen bits choose any of the sixteen banks
						cmd_addr_ff  <= addr_ff;
						cmd_banks_ff <= addr_ff[15:0];
					end
					else
					begin
						cmd_addr_ff  <= '0;
						cmd_banks_ff <= bank_mask(ba_ff, ddc_pkg::WMODE_SINGLE);
					end
				end
				default:
				begin
					cmd_addr_ff <= cmd_addr_ff;
				end
			endcase
		end
	end

	// Write data beats: store only when the mask sampled with the beat is low
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			beat_store_ff <= 1'b0;
		else
			beat_store_ff <= beat_ff & ~mask_ff;
	end

endmodule // ddc_decoder

// ### rtl/ddc_pkg.sv
package ddc_pkg;

	localparam int BANK_W = 4;
	localparam int ADDR_W = 20;
	localparam int MR_W   = 24;
	localparam int NUM_MR = 3;
	localparam int NUM_DIE = 2;

	// Mode register index carried on the bank address inputs
	localparam logic [3:0] MR_SEL_ZERO = 4'h0;
	localparam logic [3:0] MR_SEL_ONE  = 4'h1;
	localparam logic [3:0] MR_SEL_TWO  = 4'h2;

	// Field positions inside the mode registers
	localparam int MR0_RC_LSB     = 0;
	localparam int MR0_RC_MSB     = 3;
	localparam int MR2_WMODE_LSB  = 3;
	localparam int MR2_WMODE_MSB  = 4;
	localparam int MR2_REFMODE_BIT = 5;

	localparam logic [MR_W-1:0] MR_RESET_VAL = 24'h000000;

	// Write protocol encodings
	localparam logic [1:0] WMODE_SINGLE = 2'h0;
	localparam logic [1:0] WMODE_DUAL   = 2'h1;
	localparam logic [1:0] WMODE_QUAD   = 2'h2;

	typedef enum logic [4:0] {
		CMD_NOP  = 5'h01,
		CMD_MRS  = 5'h02,
		CMD_READ = 5'h04,
		CMD_WRITE = 5'h08,
		CMD_AUTO_REFRESH_CMD = 5'h10
	} ddc_cmd_t;

endpackage

// ### tb/ddc_ctrl_model.sv
module ddc_ctrl_model (
	input  wire logic        clock,
	output logic             reset_n,
	output logic             die0_select_n,
	output logic             die1_select_n,
	output logic             write_n,
	output logic             refresh_n,
	output logic [19:0]      addr,
	output logic [3:0]       bank_addr,
	output logic             write_mask,
	output logic             write_beat
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		{reset_n, die0_select_n, die1_select_n, write_n, refresh_n} = 5'h1f;
		{addr, bank_addr, write_mask, write_beat} = 26'h2;
	end
	// One cycle per command, stable across the rising edge
	task cmd(input logic [1:0] sel_n, input logic we_n, input logic rf_n, input logic [19:0] a, input logic [3:0] b);
		@(negedge clock);
		{die1_select_n, die0_select_n, write_n, refresh_n} = {sel_n, we_n, rf_n};
		{addr, bank_addr} = {a, b};
		@(negedge clock);
		{die1_select_n, die0_select_n} = 2'h3;
		// Released lines show the inverse so stale values cannot match
		{addr, bank_addr} = ~{a, b};
	endtask
	task beat(input logic m);
		@(negedge clock);
		{write_beat, write_mask} = {1'b1, m};
		@(negedge clock);
		{write_beat, write_mask} = {1'b0, ~m};
	endtask
	task pin_reset;
		@(negedge clock);
		reset_n = 1'b0;
		repeat (6) @(negedge clock);
		reset_n = 1'b1;
		repeat (8) @(negedge clock);
	endtask
endmodule // ddc_ctrl_model

// ### tb/ddc_decoder_asserts.sv
module ddc_decoder_chk (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        die0_select_n,
	input wire logic        die1_select_n,
	input wire logic        write_n,
	input wire logic        refresh_n,
	input wire logic [19:0] addr,
	input wire logic [3:0]  bank_addr,
	input wire logic        write_mask,
	input wire logic        write_beat,
	input wire logic [1:0]  cmd_die_ff,
	input wire logic        cmd_valid_ff,
	input wire logic [4:0]  cmd_code_ff,
	input wire logic [15:0] cmd_banks_ff,
	input wire logic        beat_store_ff,
	input wire logic [23:0] mode_reg_zero_ff,
	input wire logic [23:0] mode_reg_one_ff,
	input wire logic        illegal_cmd_ff
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_nop_quiet: assert property ($past(die0_select_n && die1_select_n, 2) |-> !cmd_valid_ff && cmd_die_ff == 2'h0)
		else $error("no-operation started a command");
	a_read_die: assert property ($past(!die0_select_n && die1_select_n && write_n && refresh_n, 2)
		|-> cmd_code_ff == 5'h04 && cmd_die_ff == 2'h1 && cmd_banks_ff == 16'h1 << $past(bank_addr, 2)) else $error("bad read");
	a_write_die: assert property ($past(die0_select_n && !die1_select_n && !write_n && refresh_n, 2)
		|-> cmd_valid_ff && cmd_code_ff == 5'h08 && cmd_die_ff == 2'h2) else $error("bad write");
	a_auto_refresh_cmd_both: assert property ($past(!die0_select_n && !die1_select_n && write_n && !refresh_n, 2)
		|-> cmd_code_ff == 5'h10 && cmd_die_ff == 2'h3) else $error("bad refresh");
	a_both_illegal: assert property ($past(!die0_select_n && !die1_select_n && refresh_n, 2)
		|-> illegal_cmd_ff && !cmd_valid_ff) else $error("two-die access not refused");
	a_mrs_zero: assert property ($past(!(die0_select_n && die1_select_n) && !write_n && !refresh_n && bank_addr == 4'h0, 2)
		|-> mode_reg_zero_ff == $past({bank_addr, addr}, 2)) else $error("mode value lost");
	a_mode_hold: assert property (cmd_valid_ff && cmd_code_ff != 5'h02 |-> $stable(mode_reg_one_ff))
		else $error("mode register changed");
	a_beat_mask: assert property (beat_store_ff |-> $past(write_beat && !write_mask, 2))
		else $error("masked beat stored");
	c_refresh: cover property (cmd_valid_ff && cmd_code_ff == 5'h10);
	c_illegal: cover property (illegal_cmd_ff);
	c_store: cover property (beat_store_ff);
endmodule // ddc_decoder_chk
bind ddc_decoder ddc_decoder_chk i_ddc_decoder_chk (.*);

// ### tb/dual_die_command_decoder_tb.sv
module dual_die_command_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        reset_n, die0_select_n, die1_select_n, write_n, refresh_n, write_mask, write_beat;
	logic        cmd_valid_ff, refresh_multibank_ff, beat_store_ff, illegal_cmd_ff;
	logic [19:0] addr, cmd_addr_ff;
	logic [3:0]  bank_addr, row_cycle_time_ff;
	logic [1:0]  cmd_die_ff;
	logic [4:0]  cmd_code_ff;
	logic [15:0] cmd_banks_ff;
	logic [23:0] mode_reg_zero_ff, mode_reg_one_ff, mode_reg_two_ff;
	int          mismatches = 0;
	int          samples_checked = 0;
	ddc_decoder i_ddc_decoder (.*);
	ddc_ctrl_model i_ddc_ctrl_model (.*);
	initial forever #5 clock = ~clock;
	task chk(input logic [23:0] g, input logic [23:0] e);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %0t %h %h", $time, g, e);
		end
	endtask
	// Command was captured before the model returned; one more edge brings the one-cycle pulses
	task go(input logic [1:0] s, input logic w, input logic r, input logic [19:0] a, input logic [3:0] b);
		i_ddc_ctrl_model.cmd(s, w, r, a, b);
		@(posedge clock);
		#1;
	endtask
	task t_mode;
		go(2'h0, 1'b0, 1'b0, 20'h00002, 4'h0);
		chk(mode_reg_zero_ff, 24'h000002);
		chk(row_cycle_time_ff, 24'h2);
		go(2'h3, 1'b1, 1'b1, 20'h00000, 4'h0);
		chk({mode_reg_zero_ff, cmd_valid_ff}, 25'h4);
		go(2'h1, 1'b0, 1'b0, 20'h00055, 4'h1);
		chk(mode_reg_one_ff, 24'h100055);
	endtask
	task t_read;
		go(2'h2, 1'b1, 1'b1, 20'habcde, 4'h9);
		chk({cmd_valid_ff, cmd_code_ff, cmd_die_ff}, {1'b1, 5'h04, 2'h1});
		chk({cmd_addr_ff, cmd_banks_ff[3:0]}, 24'habcde0);
		go(2'h3, 1'b0, 1'b0, 20'h00001, 4'h1);
		chk(cmd_addr_ff, 24'habcde);
		go(2'h0, 1'b1, 1'b1, 20'h00001, 4'h1);
		chk({illegal_cmd_ff, cmd_valid_ff}, 24'h2);
	endtask
	task t_write;
		logic [15:0] exp [3] = '{16'h0020, 16'h2020, 16'h2222};
		for (int m = 0; m < 3; m++)
		begin
			go(2'h2, 1'b0, 1'b0, 20'(m << 3), 4'h2);
			go(2'h1, 1'b0, 1'b1, 20'h00100, 4'h5);
			chk(cmd_banks_ff, exp[m]);
		end
	endtask
	task t_refresh;
		go(2'h0, 1'b1, 1'b0, 20'h0ffff, 4'h6);
		chk({cmd_banks_ff, cmd_addr_ff[3:0], refresh_multibank_ff}, 21'h000800);
		@(posedge clock);
		#1;
		chk(cmd_valid_ff, 24'h0);
		go(2'h2, 1'b0, 1'b0, 20'h00020, 4'h2);
		go(2'h2, 1'b1, 1'b0, 20'h000f0, 4'h3);
		chk({cmd_banks_ff, refresh_multibank_ff}, 24'h1e1);
	endtask
	task t_mask;
		go(2'h2, 1'b0, 1'b1, 20'h00040, 4'h1);
		for (int m = 0; m < 2; m++)
		begin
			i_ddc_ctrl_model.beat(1'(m));
			@(posedge clock);
			#1;
			chk(beat_store_ff, 24'(m == 0));
		end
	endtask
	task end_sim;
		if (mismatches == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clock);
		@(negedge clock) rst = 1'b0;
		repeat (4) @(posedge clock);
		t_mode;
		t_read;
		t_write;
		t_refresh;
		t_mask;
		i_ddc_ctrl_model.pin_reset();
		chk(mode_reg_zero_ff, 24'h0);
		end_sim;
	end
endmodule // dual_die_command_decoder_tb
